/* File: sfc_core.sv */
// Purpose: Serial peripheral core with slave and master modes, collision and mode fault.
// Assumes: Pins are asynchronous and pass two flip-flops; software strobes are mclk pulses.
// Notes: Slave serial clock must be slower than mclk/4 for reliable edge detection.
//
// Summary of operation
// - Slave mode uses master clock, ignores rate.
// - Slave: MOSI input, MISO output.
// - Written byte shifted out MSB first.
// - Slave transfer starts on master clock edges.
// - Byte end sets done; irq if enabled.
// - Received byte copied to read buffer.
// - Done cleared by flags access, data read.
// - Data writes ignored while done set, until a flags read.
// - Eight clock pulses, full duplex.
// - Idle level sets clock rest level.
// - Phase set: second edge captures.
// - Phase clear: first edge captures.
// - Phase clear: low select freezes data.
// - Phase set: first edge freezes data.
// - Write during transfer discarded.
// - Collision sets flag, no interrupt.
// - Select low in master: mode fault.
// - Fault cleared by flags read, control write.
// - Fault blocks setting enable and master.
// - Overrun keeps first byte, no indication.
// - Irq on either flag rising alone.
// - Master rate divides by 2,4,16,32.
// - Master transfer starts on data write.
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_core
  import sfc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] ctl_wdata,
  input wire logic ctl_we,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  input wire logic data_re,
  input wire logic flags_re,
  output logic [7:0] serial_control_reg,
  output logic [7:0] serial_flags_reg,
  output logic [7:0] serial_data_reg,
  output logic irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_n_s;
  sfc_sync u_sck (.mclk(mclk), .rst(rst), .ce(ce), .rst_val(1'b0), .d(sck_in), .q(sck_s));
  sfc_sync u_mosi (.mclk(mclk), .rst(rst), .ce(ce), .rst_val(1'b0), .d(mosi_in), .q(mosi_s));
  sfc_sync u_miso (.mclk(mclk), .rst(rst), .ce(ce), .rst_val(1'b0), .d(miso_in), .q(miso_s));
  sfc_sync u_ss (.mclk(mclk), .rst(rst), .ce(ce), .rst_val(1'b1), .d(ss_n), .q(ss_n_s));

  // ****************************************
  // State
  // ****************************************
  sfc_state_t st_r, st_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] rxbuf_r, rxbuf_nxt;
  logic [3:0] edges_r, edges_nxt;
  logic [4:0] div_r, div_nxt;
  logic sck_prev_r, sck_prev_nxt;
  logic msck_r, msck_nxt;
  logic done_r, done_nxt;
  logic write_collision_flag_r, write_collision_flag_nxt;
  logic mode_fault_flag_r, mode_fault_flag_nxt;
  logic done_armed_r, done_armed_nxt;
  logic write_collision_flag_armed_r, write_collision_flag_armed_nxt;
  logic mode_fault_flag_armed_r, mode_fault_flag_armed_nxt;
  logic frozen_r, frozen_nxt;
  logic out_bit_r, out_bit_nxt;
  logic irq_r, irq_nxt;

  logic master;
  logic phase;
  logic idle_lvl;
  logic pin_oe;
  logic clk_now;
  logic edge_seen;
  logic lead_edge;
  logic capture;
  logic in_bit;
  logic [4:0] half_div;
  logic write_ok;
  logic fault;
  logic busy;
  logic finish;

  always_comb begin
    master = ctl_r[`SFC_CTL_MASTER];
    phase = ctl_r[`SFC_CTL_PHASE];
    idle_lvl = ctl_r[`SFC_CTL_IDLE_LVL];
    pin_oe = ctl_r[`SFC_CTL_PIN_OE];
    case (ctl_r[`SFC_CTL_RATE_HI:`SFC_CTL_RATE_LO])
      2'b00: half_div = `SFC_HALF_DIV0;
      2'b01: half_div = `SFC_HALF_DIV1;
      2'b10: half_div = `SFC_HALF_DIV2;
      default: half_div = `SFC_HALF_DIV3;
    endcase
    clk_now = master ? msck_r : sck_s;
    edge_seen = master ? (st_r == SFC_ACTIVE && div_r == half_div) : (clk_now != sck_prev_r);
    // odd edges lead, capture depends on phase
    lead_edge = (edges_r[0] == 1'b0);
    capture = phase ? !lead_edge : lead_edge;
    in_bit = master ? miso_s : mosi_s;
    busy = master ? (st_r == SFC_ACTIVE) : (!ss_n_s && (!phase || frozen_r));
    fault = master && !ss_n_s;
    write_ok = !done_r && !busy;
    finish = edge_seen && edges_r == `SFC_LAST_EDGE;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    ctl_nxt = ctl_r;
    shift_nxt = shift_r;
    rxbuf_nxt = rxbuf_r;
    edges_nxt = edges_r;
    div_nxt = div_r;
    sck_prev_nxt = sck_s;
    msck_nxt = msck_r;
    done_nxt = done_r;
    write_collision_flag_nxt = write_collision_flag_r;
    mode_fault_flag_nxt = mode_fault_flag_r;
    done_armed_nxt = done_armed_r;
    write_collision_flag_armed_nxt = write_collision_flag_armed_r;
    mode_fault_flag_armed_nxt = mode_fault_flag_armed_r;
    frozen_nxt = frozen_r;
    out_bit_nxt = out_bit_r;
    if (st_r == SFC_IDLE) begin
      msck_nxt = idle_lvl;
    end
    // clearing sequences arm on flags access
    if (flags_re) begin
      done_armed_nxt = done_r;
      write_collision_flag_armed_nxt = write_collision_flag_r;
      mode_fault_flag_armed_nxt = mode_fault_flag_r;
    end
    if (data_re && done_armed_r) begin
      done_nxt = 1'b0;
      done_armed_nxt = 1'b0;
    end
    if ((data_re || data_we) && write_collision_flag_armed_r) begin
      write_collision_flag_nxt = 1'b0;
      write_collision_flag_armed_nxt = 1'b0;
    end
    // flags read arms done and releases write lock before data read clears it
    if (data_we) begin
      if (write_ok || (done_armed_r && !busy)) begin
        shift_nxt = data_wdata;
        out_bit_nxt = data_wdata[7];
        if (master) begin
          st_nxt = SFC_ACTIVE;
          edges_nxt = 4'h0;
          div_nxt = 5'h00;
          msck_nxt = idle_lvl;
        end
      end else if (busy) begin
        write_collision_flag_nxt = 1'b1;
      end
    end
    if (ctl_we) begin
      ctl_nxt = ctl_wdata;
      if (mode_fault_flag_r && !mode_fault_flag_armed_r) begin
        ctl_nxt[`SFC_CTL_PIN_OE] = 1'b0;
        ctl_nxt[`SFC_CTL_MASTER] = 1'b0;
      end
      if (mode_fault_flag_armed_r) begin
        mode_fault_flag_nxt = 1'b0;
        mode_fault_flag_armed_nxt = 1'b0;
      end
    end
    if (!master && ss_n_s) begin
      frozen_nxt = 1'b0;
      edges_nxt = 4'h0;
      st_nxt = SFC_IDLE;
    end
    if (master && st_r == SFC_ACTIVE) begin
      div_nxt = (div_r == half_div) ? 5'h00 : div_r + 5'h01;
      if (div_r == half_div) begin
        msck_nxt = !msck_r;
      end
    end
    if (edge_seen && (master || !ss_n_s)) begin
      st_nxt = SFC_ACTIVE;
      frozen_nxt = 1'b1;
      edges_nxt = edges_r + 4'h1;
      if (capture) begin
        shift_nxt = {shift_r[6:0], in_bit};
      end else begin
        out_bit_nxt = shift_r[7];
      end
      if (finish) begin
        st_nxt = SFC_IDLE;
        edges_nxt = 4'h0;
        frozen_nxt = 1'b0;
        msck_nxt = idle_lvl;
        done_nxt = 1'b1;
        if (!done_r) begin
          rxbuf_nxt = capture ? {shift_r[6:0], in_bit} : shift_r;
        end
      end
    end
    // fault forces slave and disables pins
    if (fault) begin
      mode_fault_flag_nxt = 1'b1;
      ctl_nxt[`SFC_CTL_PIN_OE] = 1'b0;
      ctl_nxt[`SFC_CTL_MASTER] = 1'b0;
      st_nxt = SFC_IDLE;
      edges_nxt = 4'h0;
    end
    irq_nxt = ctl_r[`SFC_CTL_IRQ_EN] && ctl_r[`SFC_CTL_IRQ_SRC] &&
              ((done_nxt && !done_r && !mode_fault_flag_r) || (mode_fault_flag_nxt && !mode_fault_flag_r && !done_r));
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= SFC_IDLE;
      ctl_r <= `SFC_CTL_RESET;
      shift_r <= 8'h00;
      rxbuf_r <= 8'h00;
      edges_r <= 4'h0;
      div_r <= 5'h00;
      sck_prev_r <= 1'b0;
      msck_r <= 1'b0;
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      done_armed_r <= 1'b0;
      write_collision_flag_armed_r <= 1'b0;
      mode_fault_flag_armed_r <= 1'b0;
      frozen_r <= 1'b0;
      out_bit_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      shift_r <= shift_nxt;
      rxbuf_r <= rxbuf_nxt;
      edges_r <= edges_nxt;
      div_r <= div_nxt;
      sck_prev_r <= sck_prev_nxt;
      msck_r <= msck_nxt;
      done_r <= done_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      mode_fault_flag_r <= mode_fault_flag_nxt;
      done_armed_r <= done_armed_nxt;
      write_collision_flag_armed_r <= write_collision_flag_armed_nxt;
      mode_fault_flag_armed_r <= mode_fault_flag_armed_nxt;
      frozen_r <= frozen_nxt;
      out_bit_r <= out_bit_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    serial_control_reg = ctl_r;
    serial_flags_reg = {done_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
    serial_data_reg = rxbuf_r;
    irq = irq_r;
    // master clock rests at idle level
    sck_out = master ? msck_r : idle_lvl;
    sck_oe = pin_oe && master;
    mosi_out = out_bit_r;
    mosi_oe = pin_oe && master;
    miso_out = out_bit_r;
    miso_oe = pin_oe && !master && !ss_n_s;
  end
endmodule : sfc_core

/* File: sfc_core_sva.sv */
// Purpose: Port checker for the serial core.
// Assumes: One mclk domain, rst synchronous.
// Notes: Flags bit 7 done, 6 collision, 4 fault.
`timescale 1ns/1ps
module sfc_core_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic data_we,
  input wire logic data_re,
  input wire logic ss_n,
  input wire logic [7:0] serial_control_reg,
  input wire logic [7:0] serial_flags_reg,
  input wire logic [7:0] serial_data_reg,
  input wire logic irq,
  input wire logic mosi_oe,
  input wire logic sck_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic [7:0] c = serial_control_reg;
  wire logic [7:0] f = serial_flags_reg;
  sequence s_fault; $rose(f[4]); endsequence
  sequence s_freed; !c[6] && !c[4]; endsequence
  property p_fault_off; s_fault |-> s_freed; endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault left pins on");
  property p_fault_set; c[4] && !ss_n |-> ##[1:5] f[4]; endproperty
  a_fault_set: assert property (p_fault_set) else $error("no fault flag");
  property p_fault_cause; s_fault |-> $past(c[4]); endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault in slave");
  property p_fault_lock; f[4] |-> !$rose(c[6]) && !$rose(c[4]); endproperty
  a_fault_lock: assert property (p_fault_lock) else $error("bits set in fault");
  property p_done_clear; $fell(f[7]) |-> $past(data_re); endproperty
  a_done_clear: assert property (p_done_clear) else $error("done fell early");
  property p_buf_hold; f[7] && $past(f[7]) |-> $stable(serial_data_reg); endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffer overwritten");
  property p_coll_cause; $rose(f[6]) |-> $past(data_we); endproperty
  a_coll_cause: assert property (p_coll_cause) else $error("stray collision");
  property p_irq_pulse; irq |-> c[7] && c[5] && (f[7] || f[4]) ##1 !irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("bad irq");
  property p_slave_pins; (!c[4] && c[6]) [*3] |-> !mosi_oe && !sck_oe; endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave drives input");
endmodule : sfc_core_sva

bind sfc_core sfc_core_sva u_sva (.mclk(mclk), .rst(rst), .data_we(data_we),
  .data_re(data_re), .ss_n(ss_n), .serial_control_reg(serial_control_reg),
  .serial_flags_reg(serial_flags_reg), .serial_data_reg(serial_data_reg),
  .irq(irq), .mosi_oe(mosi_oe), .sck_oe(sck_oe));

/* File: sfc_defines.svh */
// Purpose: Constants for the serial peripheral with fault and collision handling.
// Assumes: Included by bare name; definitions only.
// Notes: Bit positions refer to the control and flags registers.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
`define SFC_CTL_IRQ_EN 7
`define SFC_CTL_PIN_OE 6
`define SFC_CTL_IRQ_SRC 5
`define SFC_CTL_MASTER 4
`define SFC_CTL_IDLE_LVL 3
`define SFC_CTL_PHASE 2
`define SFC_CTL_RATE_HI 1
`define SFC_CTL_RATE_LO 0
`define SFC_FLG_DONE 7
`define SFC_FLG_WRITE_COLLISION_FLAG 6
`define SFC_FLG_MODE_FAULT_FLAG 4
`define SFC_CTL_RESET 8'h00
`define SFC_BITS_PER_BYTE 4'h8
`define SFC_LAST_EDGE 4'hf
`define SFC_HALF_DIV0 5'h00
`define SFC_HALF_DIV1 5'h01
`define SFC_HALF_DIV2 5'h07
`define SFC_HALF_DIV3 5'h0f
`endif

/* File: sfc_master_model.sv */
// Purpose: Behavioural external master on the serial pins.
// Assumes: Half period well above four mclk cycles.
// Notes: Clock rests at its idle level between frames.
`timescale 1ns/1ps
module sfc_master_model #(
  parameter int HALF_NS = 600
) (
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  task automatic sel(input logic v);
    ss_n = v;
  endtask : sel
  task automatic xfer(input logic clock_idle_level, input logic clock_capture_phase, input logic [7:0] tx,
                      output logic [7:0] rx);
    int i;
    sck = clock_idle_level;
    #(HALF_NS) ss_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      if (!clock_capture_phase) mosi = tx[i];
      #(HALF_NS) sck = ~sck;
      if (clock_capture_phase) mosi = tx[i];
      else rx[i] = miso;
      #(HALF_NS) sck = ~sck;
      if (clock_capture_phase) rx[i] = miso;
    end
    #(HALF_NS) ss_n = 1'b1;
    // Released line must not keep the last bit.
    mosi = ~mosi;
  endtask : xfer
endmodule : sfc_master_model

/* File: sfc_pkg.sv */
// Purpose: Types shared by the serial peripheral files.
// Assumes: Nothing beyond the defines header.
// Notes: Types only.
package sfc_pkg;
  typedef enum logic [1:0] {SFC_IDLE, SFC_ACTIVE, SFC_DONE} sfc_state_t;
endpackage : sfc_pkg

/* File: sfc_sync.sv */
// Purpose: Two-stage synchroniser for one pin.
// Assumes: Single mclk domain.
// Notes: First stage feeds only the second.
`timescale 1ns/1ps
module sfc_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rst_val,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s1_nxt;
  logic s2_nxt;
  always_comb begin
    s1_nxt = ce ? d : s1_r;
    s2_nxt = ce ? s1_r : q;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      // Reset to the pin's idle level so no false edge or select follows reset.
      s1_r <= rst_val;
      q <= rst_val;
    end else begin
      s1_r <= s1_nxt;
      q <= s2_nxt;
    end
  end
endmodule : sfc_sync

/* File: tb.sv */
// Purpose: Self-checking bench for the serial core in slave and master use.
// Assumes: Strobes last one mclk cycle.
// Notes: Master mode is checked with MISO looped back inverted.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] ctl_wdata = 8'h00;
  logic [7:0] data_wdata = 8'h00;
  logic ctl_we = 1'b0;
  logic data_we = 1'b0;
  logic data_re = 1'b0;
  logic flags_re = 1'b0;
  logic [7:0] ctl_q, flg_q, buf_q, irq_cnt;
  logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, m_sck, m_mosi, ss_n;
  int fail_count = 0;
  int n_compared = 0;
  logic [17:0] rows [4] = '{{2'h0, 8'ha5, 8'h3c}, {2'h1, 8'h81, 8'h7e},
                            {2'h2, 8'h01, 8'h80}, {2'h3, 8'hff, 8'h5a}};
  logic [7:0] spans [4] = '{8'h0f, 8'h1e, 8'h78, 8'hf0};
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (rst) irq_cnt <= 8'h00; else if (irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
  sfc_core DUT (.mclk(mclk), .rst(rst), .ce(ce), .ctl_wdata(ctl_wdata), .ctl_we(ctl_we),
    .data_wdata(data_wdata), .data_we(data_we), .data_re(data_re), .flags_re(flags_re),
    .serial_control_reg(ctl_q), .serial_flags_reg(flg_q), .serial_data_reg(buf_q),
    .irq(irq), .sck_in(sck_oe ? sck_out : m_sck), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_oe ? mosi_out : m_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(~miso_out), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n(ss_n));
  sfc_master_model u_mst (.sck(m_sck), .mosi(m_mosi), .ss_n(ss_n),
    .miso(miso_oe ? miso_out : ~miso_out));
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge mclk);
    ctl_wdata <= v;
    data_wdata <= v;
    ctl_we <= (k == 0);
    data_we <= (k == 1);
    data_re <= (k == 2);
    flags_re <= (k == 3);
    @(posedge mclk);
    {ctl_we, data_we, data_re, flags_re} <= 4'h0;
    @(negedge mclk);
  endtask : strobe
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_done;
    repeat (300) if (flg_q[7] !== 1'b1) @(negedge mclk);
    repeat (4) @(negedge mclk);
  endtask : wait_done
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [7:0] got, base;
    logic [7:0] mrx;
    logic last;
    int tog;
    int span;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk(ctl_q | flg_q | buf_q, 8'h00);
    for (int i = 0; i < 4; i++) begin
      strobe(0, {4'he, rows[i][17:16], 2'h3});
      strobe(1, rows[i][15:8]);
      u_mst.xfer(rows[i][17], rows[i][16], rows[i][7:0], got);
      wait_done();
      chk(got, rows[i][15:8]);
      strobe(3, 8'h00);
      strobe(2, 8'h00);
      chk(buf_q, rows[i][7:0]);
      chk(flg_q, 8'h00);
      chk(irq_cnt, 8'(i + 1));
    end
    strobe(1, 8'h3c);
    u_mst.xfer(1'b1, 1'b1, 8'h81, got);
    wait_done();
    chk(got, 8'h3c);
    strobe(1, 8'h55);
    u_mst.xfer(1'b1, 1'b1, 8'h7e, got);
    wait_done();
    chk(got, 8'h81);
    chk(buf_q, 8'h81);
    strobe(3, 8'h00);
    strobe(2, 8'h00);
    strobe(0, 8'he0);
    strobe(1, 8'ha5);
    base = irq_cnt;
    fork
      u_mst.xfer(1'b0, 1'b0, 8'h18, got);
      #3000 strobe(1, 8'h00);
    join
    wait_done();
    chk(got, 8'ha5);
    chk(flg_q & 8'h40, 8'h40);
    chk(irq_cnt, base + 8'h01);
    strobe(3, 8'h00);
    strobe(2, 8'h00);
    chk(buf_q, 8'h18);
    chk(flg_q & 8'h40, 8'h00);
    strobe(0, 8'hf0);
    u_mst.sel(1'b0);
    repeat (8) @(negedge mclk);
    chk(ctl_q & 8'h50, 8'h00);
    chk(irq_cnt, base + 8'h02);
    u_mst.sel(1'b1);
    strobe(0, 8'hf0);
    chk(ctl_q & 8'h50, 8'h00);
    chk(flg_q & 8'h10, 8'h10);
    strobe(3, 8'h00);
    strobe(0, 8'he0);
    @(negedge mclk);
    chk(flg_q & 8'h10, 8'h00);
    chk(ctl_q, 8'he0);
    // Master loopback: MISO is the inverse of this block's own output.
    for (int r = 0; r < 4; r++) begin
      strobe(0, {6'h3c, 2'(r)});
      strobe(1, 8'h96);
      tog = 0;
      span = 0;
      mrx = 8'h00;
      last = sck_out;
      for (int c = 0; c < 600; c++) begin
        @(negedge mclk);
        if (tog > 0 && tog < 16) span++;
        if (sck_out === 1'b1 && last === 1'b0) mrx = {mrx[6:0], mosi_out};
        if (sck_out !== last) tog++;
        last = sck_out;
      end
      chk(8'(tog), 8'h10);
      chk(8'(span), spans[r]);
      chk(mrx, 8'h96);
      strobe(3, 8'h00);
      strobe(2, 8'h00);
    end
    chk(buf_q, 8'h69);
    chk(irq_cnt, base + 8'h06);
    @(posedge mclk);
    ce <= 1'b0;
    strobe(0, 8'h00);
    chk(ctl_q, 8'hf3);
    @(posedge mclk);
    ce <= 1'b1;
    wrap_up();
  end
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
endmodule : tb
